//--- sar_conversion_sequencer_test.sv
// self-checking testbench of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_conversion_sequencer_test;
   import sarcs_pkg::*;
   typedef struct packed {logic [15:0] smp; logic cod; logic hi; logic bip; logic [15:0] res; logic [1:0] rng;} sarcs_row_s;
   localparam sarcs_row_s ROWS [8] = '{
      '{16'h8000, 1'b1, 1'b0, 1'b0, 16'h8000, 2'b00},
      '{16'h8000, 1'b0, 1'b0, 1'b1, 16'h0000, 2'b01},
      '{16'hffff, 1'b0, 1'b1, 1'b1, 16'h7fff, 2'b11},
      '{16'h0000, 1'b0, 1'b1, 1'b0, 16'h8000, 2'b10},
      '{16'h0000, 1'b1, 1'b0, 1'b0, 16'h0000, 2'b00},
      '{16'ha5c3, 1'b1, 1'b1, 1'b0, 16'ha5c3, 2'b10},
      '{16'h0001, 1'b0, 1'b0, 1'b0, 16'h8001, 2'b00},
      '{16'hffff, 1'b1, 1'b0, 1'b1, 16'hffff, 2'b01}};
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic        conversion_start_n = 1'b1;
   logic        output_coding_select = 1'b1;
   logic        high_range_select = 1'b0;
   logic        bipolar_select = 1'b0;
   logic        interface_select = 1'b1;
   logic        config_source_select = 1'b0;
   logic [15:0] analog_level = 16'h0;
   logic        comparator_out, busy, sampling_switch_pos, sampling_switch_neg, array_to_inputs;
   logic [15:0] capacitive_search_array, result_data;
   logic [1:0]  active_range, s_axi_bresp, s_axi_rresp;
   logic [3:0]  s_axi_awaddr = 4'h0;
   logic [3:0]  s_axi_araddr = 4'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [31:0] s_axi_rdata;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int          error_cnt = 0;
   int          checked = 0;

   always #12.5 clock = ~clock;

   sarcs_main DUT (.clock, .rst, .ce, .conversion_start_n, .output_coding_select, .high_range_select,
      .bipolar_select, .interface_select, .config_source_select, .comparator_out, .busy,
      .sampling_switch_pos, .sampling_switch_neg, .array_to_inputs, .capacitive_search_array, .result_data,
      .active_range, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   sarcs_front_model front (.clock, .sampling_switch_pos, .array_to_inputs, .capacitive_search_array,
      .analog_level, .comparator_out);

   // =========================================
   // tasks
   // =========================================
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(r));
   endtask

   task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, d);
      chk(32'(s_axi_rresp), 32'(r));
   endtask

   task automatic convert(input logic [15:0] lvl, input logic glitch, input logic [15:0] res);
      int n;
      n = 0;
      @(posedge clock);
      analog_level <= lvl;
      repeat (3) @(posedge clock);
      conversion_start_n <= 1'b0;
      for (int k = 0; k < 60; k++)
      begin
         @(posedge clock);
         if (busy === 1'b1) n++;
         else if (n > 0) break;
         if (n == 1 || n == 2) chk(32'({sampling_switch_pos, sampling_switch_neg, array_to_inputs}), 32'(n == 1));
         if (n == 3) chk(32'(capacitive_search_array), 32'h8000);
         if (glitch && n == 5) conversion_start_n <= 1'b1;
         if (glitch && n == 7)
         begin
            conversion_start_n <= 1'b0;
            output_coding_select <= ~output_coding_select;
         end
         if (glitch && n == 9) ce <= 1'b0;
         if (glitch && n == 13) ce <= 1'b1;
      end
      chk(32'(n), glitch ? 32'd23 : 32'd19);
      chk(32'(result_data), 32'(res));
      repeat (3) @(posedge clock);
      chk(32'(busy), 32'd0);
      conversion_start_n <= 1'b1;
   endtask

   task automatic tally_and_finish;
      $display("mismatches %0d, checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
      begin
         $display("== PASSED ==");
      end
      else
      begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // =========================================
   // sequence
   // =========================================
   initial
   begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      tally_and_finish;
   end

   initial
   begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      chk(32'({busy, sampling_switch_pos, array_to_inputs, active_range}), 32'h0c);
      chk(32'(result_data), 32'h0);
      axi_rd(ADDR_CFG, 32'(CFG_RESET));
      interface_select <= 1'b0;
      foreach (ROWS[i])
      begin
         @(posedge clock);
         output_coding_select <= ROWS[i].cod;
         high_range_select <= ROWS[i].hi;
         bipolar_select <= ROWS[i].bip;
         convert(ROWS[i].smp, 1'b0, ROWS[i].res);
         chk(32'(active_range), 32'(ROWS[i].rng));
         axi_rd(ADDR_RESULT, {16'h0, ROWS[i].res});
      end
      convert(16'h1234, 1'b1, 16'h1234);
      convert(16'h1234, 1'b0, 16'h9234);
      @(posedge clock);
      interface_select <= 1'b1;
      output_coding_select <= 1'b1;
      bipolar_select <= 1'b0;
      high_range_select <= 1'b0;
      axi_wr(ADDR_CFG, 32'h3, RESP_OKAY);
      axi_wr(ADDR_STATUS, 32'h7, RESP_SLVERR);
      convert(16'hffff, 1'b0, 16'h7fff);
      chk(32'(active_range), 32'h3);
      axi_rd(ADDR_ACTIVE, 32'h3);
      axi_rd(ADDR_CFG, 32'h3);
      axi_rd(4'h1, 32'h0, RESP_SLVERR);
      @(posedge clock);
      config_source_select <= 1'b1;
      convert(16'hffff, 1'b0, 16'hffff);
      chk(32'(active_range), 32'h0);
      @(posedge clock);
      conversion_start_n <= 1'b0;
      repeat (6) @(posedge clock);
      chk(32'(busy), 32'd1);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      conversion_start_n <= 1'b1;
      repeat (2) @(posedge clock);
      chk(32'({busy, sampling_switch_pos, array_to_inputs, active_range}), 32'h0c);
      chk(32'(result_data), 32'h0);
      axi_rd(ADDR_CFG, 32'(CFG_RESET));
      convert(16'h0001, 1'b0, 16'h0001);
      tally_and_finish;
   end
endmodule
`default_nettype wire

//--- sarcs_cfg_latch.sv
// range and coding configuration latch, updated during acquisition
`timescale 1ns/1ps
`default_nettype none
module sarcs_cfg_latch
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       acquiring,
   input  wire logic [2:0] cfg_in,
   output var  logic [2:0] cfg_ff
);
   import sarcs_pkg::*;
   // =========================================
   // reload on every enabled clock while acquiring
   // =========================================
   always_ff @(posedge clock)
   begin
      if (rst)
         cfg_ff <= CFG_RESET;
      else if (ce && acquiring)
         cfg_ff <= cfg_in;
   end
endmodule
`default_nettype wire

//--- sarcs_front_model.sv
// front-end model: holds the sample and answers each comparator trial
`timescale 1ns/1ps
`default_nettype none
module sarcs_front_model
(
   input  wire logic        clock,
   input  wire logic        sampling_switch_pos,
   input  wire logic        array_to_inputs,
   input  wire logic [15:0] capacitive_search_array,
   input  wire logic [15:0] analog_level,
   output var  logic        comparator_out
);
   logic [15:0] held_ff;
   logic        junk_ff;
   // =========================================
   // track while switches closed, hold once opened
   // =========================================
   always_ff @(posedge clock)
   begin
      junk_ff <= (junk_ff === 1'b1) ? 1'b0 : 1'b1;
      if (sampling_switch_pos)
      begin
         held_ff <= analog_level;
      end
   end
   // outside the search the comparator output is meaningless
   always_comb
   begin
      comparator_out = array_to_inputs ? junk_ff : (held_ff >= capacitive_search_array);
   end
endmodule
`default_nettype wire

//--- sarcs_main.sv
// sar conversion sequencer with axi4-lite configuration slave
`timescale 1ns/1ps
`default_nettype none
module sarcs_main
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        conversion_start_n,
   input  wire logic        output_coding_select,
   input  wire logic        high_range_select,
   input  wire logic        bipolar_select,
   input  wire logic        interface_select,
   input  wire logic        config_source_select,
   input  wire logic        comparator_out,
   output var  logic        busy,
   output var  logic        sampling_switch_pos,
   output var  logic        sampling_switch_neg,
   output var  logic        array_to_inputs,
   output var  logic [15:0] capacitive_search_array,
   output var  logic [15:0] result_data,
   output var  logic [1:0]  active_range,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   import sarcs_pkg::*;

   // elaboration-time throughput check
   if (RES_BITS + 4 > CYCLE_CLKS)
   begin : g_budget_check
      $error("conversion does not fit the throughput budget");
   end

   sarcs_state_e state_ff;
   logic [4:0]   bit_ff;
   logic [15:0]  trial_ff;
   logic         start_d_ff;
   logic [2:0]   sw_cfg_ff;
   logic [2:0]   cfg_sel;
   logic [2:0]   cfg_act;
   logic         soft_mode;
   logic         start_fall;
   logic [15:0]  raw_code;

   // =========================================
   // configuration source selection
   // =========================================
   assign soft_mode = interface_select && !config_source_select;
   always_comb
   begin
      if (soft_mode)
         cfg_sel = sw_cfg_ff;
      else
         cfg_sel = {output_coding_select, high_range_select, bipolar_select};
   end

   // accepted at any time, applied while acquiring
   sarcs_cfg_latch u_cfg
   (
      .clock     (clock),
      .rst       (rst),
      .ce        (ce),
      .acquiring (state_ff == SARCS_ACQ),
      .cfg_in    (cfg_sel),
      .cfg_ff    (cfg_act)
   );

   assign active_range = {cfg_act[CFG_HIGH_RANGE], cfg_act[CFG_BIPOLAR]};

   // =========================================
   // start edge detect
   // =========================================
   always_ff @(posedge clock)
   begin
      if (rst)
         start_d_ff <= 1'b1;
      else if (ce)
         start_d_ff <= conversion_start_n;
   end
   assign start_fall = start_d_ff && !conversion_start_n;

   // =========================================
   // conversion sequencer
   // =========================================
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_ff <= SARCS_ACQ;
         bit_ff   <= 5'h0f;
         trial_ff <= 16'h0000;
      end
      else if (ce)
      begin
         case (state_ff)
            SARCS_ACQ:
               if (start_fall)
                  state_ff <= SARCS_HOLD;
            SARCS_HOLD:
               state_ff <= SARCS_XFER;
            SARCS_XFER:
            begin
               state_ff <= SARCS_TRIAL;
               bit_ff   <= 5'h0f;
               trial_ff <= CODE_MID;
            end
            SARCS_TRIAL:
            begin
               if (!comparator_out)
                  trial_ff[bit_ff[3:0]] <= 1'b0;
               if (bit_ff != 5'h00)
                  trial_ff[bit_ff[3:0] - 4'h1] <= 1'b1;
               if (bit_ff == 5'h00)
                  state_ff <= SARCS_CODE;
               else
                  bit_ff <= bit_ff - 5'h01;
            end
            SARCS_CODE:
               state_ff <= SARCS_ACQ;
            default:
               state_ff <= SARCS_ACQ;
         endcase
      end
   end

   assign busy                    = (state_ff != SARCS_ACQ);
   assign sampling_switch_pos     = (state_ff == SARCS_ACQ);
   assign sampling_switch_neg     = (state_ff == SARCS_ACQ);
   assign array_to_inputs         = (state_ff == SARCS_ACQ) || (state_ff == SARCS_HOLD);
   assign capacitive_search_array = (state_ff == SARCS_TRIAL) ? trial_ff : 16'h0000;

   // =========================================
   // output coding
   // =========================================
   assign raw_code = trial_ff;
   always_ff @(posedge clock)
   begin
      if (rst)
         result_data <= 16'h0000;
      else if (ce && state_ff == SARCS_CODE)
      begin
         if (cfg_act[CFG_CODING])
            result_data <= raw_code;
         else
            result_data <= raw_code ^ CODE_MID;
      end
   end

   // =========================================
   // axi4-lite slave
   // =========================================
   logic        aw_ok;
   logic        w_ok;
   logic [3:0]  aw_ff;
   logic [31:0] w_ff;
   logic [3:0]  ws_ff;

   assign s_axi_awready = !aw_ok && !s_axi_bvalid;
   assign s_axi_wready  = !w_ok && !s_axi_bvalid;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         aw_ok        <= 1'b0;
         w_ok         <= 1'b0;
         aw_ff        <= 4'h0;
         w_ff         <= 32'h00000000;
         ws_ff        <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         sw_cfg_ff    <= CFG_RESET;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_ok <= 1'b1;
            aw_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ok  <= 1'b1;
            w_ff  <= s_axi_wdata;
            ws_ff <= s_axi_wstrb;
         end
         if (aw_ok && w_ok)
         begin
            aw_ok        <= 1'b0;
            w_ok         <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_ff == ADDR_CFG)
            begin
               s_axi_bresp <= RESP_OKAY;
               if (ws_ff[0])
                  sw_cfg_ff <= w_ff[2:0];
            end
            else
               s_axi_bresp <= RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (s_axi_araddr)
               ADDR_CFG:    s_axi_rdata <= {29'h0, sw_cfg_ff};
               ADDR_STATUS: s_axi_rdata <= {28'h0, soft_mode, state_ff};
               ADDR_RESULT: s_axi_rdata <= {16'h0, result_data};
               ADDR_ACTIVE: s_axi_rdata <= {29'h0, cfg_act};
               default:
               begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // =========================================
   // assertions
   // =========================================
   sequence s_start;
      ce && state_ff == SARCS_ACQ && start_fall;
   endsequence
   sequence s_search;
      busy [*8];
   endsequence

   a_start_busy: assert property (@(posedge clock) disable iff (rst)
      s_start |=> busy) else $error("busy not raised on start");
   a_busy_span: assert property (@(posedge clock) disable iff (rst)
      s_start ##1 ce[*8] |-> s_search) else $error("busy dropped early");
   a_switch_open: assert property (@(posedge clock) disable iff (rst)
      busy |-> !sampling_switch_pos && !sampling_switch_neg) else $error("switch closed in conversion");
   a_switch_order: assert property (@(posedge clock) disable iff (rst)
      state_ff == SARCS_HOLD |-> array_to_inputs && !sampling_switch_pos) else $error("array moved early");
   a_code_done: assert property (@(posedge clock) disable iff (rst)
      ce && state_ff == SARCS_CODE |=> !busy) else $error("busy not released");
   a_mid_code: assert property (@(posedge clock) disable iff (rst)
      ce && state_ff == SARCS_CODE && raw_code == CODE_MID && !cfg_act[CFG_CODING]
      |=> result_data == 16'h0000) else $error("midscale twos complement wrong");
   a_top_code: assert property (@(posedge clock) disable iff (rst)
      ce && state_ff == SARCS_CODE && raw_code == CODE_TOP_SB && !cfg_act[CFG_CODING]
      |=> result_data == CODE_TOP_TC) else $error("top twos complement wrong");
   a_cfg_apply: assert property (@(posedge clock) disable iff (rst)
      ce && !busy |=> cfg_act == $past(cfg_sel)) else $error("config not applied");
   a_ignore_busy: assert property (@(posedge clock) disable iff (rst)
      busy && state_ff != SARCS_CODE |=> busy) else $error("busy ended mid conversion");
   a_soft_pin: assert property (@(posedge clock) disable iff (rst)
      ce && !busy && soft_mode |=> cfg_act == $past(sw_cfg_ff)) else $error("pin used in software mode");
endmodule
`default_nettype wire

//--- sarcs_pkg.sv
// package of constants for the conversion sequencer
package sarcs_pkg;
   // =========================================
   // timing
   // =========================================
   localparam int unsigned CLK_HZ          = 40000000;
   localparam int unsigned THROUGHPUT_SPS  = 250000;
   // full cycle budget per conversion at the top rate
   localparam int unsigned CYCLE_CLKS      = CLK_HZ / THROUGHPUT_SPS;
   localparam int unsigned RES_BITS        = 16;
   localparam int unsigned SWITCH_CLKS     = 1;
   // =========================================
   // output codes
   // =========================================
   localparam logic [15:0] CODE_MID        = 16'h8000;
   localparam logic [15:0] CODE_TOP_SB     = 16'hffff;
   localparam logic [15:0] CODE_TOP_TC     = 16'h7fff;
   // =========================================
   // register map (axi4-lite byte addresses)
   // =========================================
   localparam logic [3:0] ADDR_CFG         = 4'h0;
   localparam logic [3:0] ADDR_STATUS      = 4'h4;
   localparam logic [3:0] ADDR_RESULT      = 4'h8;
   localparam logic [3:0] ADDR_ACTIVE      = 4'hc;
   // cfg fields
   localparam int unsigned CFG_BIPOLAR     = 0;
   localparam int unsigned CFG_HIGH_RANGE  = 1;
   localparam int unsigned CFG_CODING      = 2;
   localparam logic [2:0] CFG_RESET        = 3'h4;
   localparam logic [1:0] RESP_OKAY        = 2'h0;
   localparam logic [1:0] RESP_SLVERR      = 2'h2;

   typedef enum logic [2:0]
   {
      SARCS_ACQ   = 3'b000,
      SARCS_HOLD  = 3'b001,
      SARCS_XFER  = 3'b010,
      SARCS_TRIAL = 3'b011,
      SARCS_CODE  = 3'b100
   } sarcs_state_e;
endpackage
